/* rfvc_engine.sv */
// Purpose: Command execution of the reader: value blocks, login, parameter store, resets.
// Assumes: Framing layer delivers one parsed command at a time; tag and store ports answer
//          with one-cycle done pulses.
// Notes:   One answer per accepted command except reset, which gives none; the next command is taken only when idle.

`timescale 1ns/1ns

module rfvc_engine
	import rfvc_pkg::*;
#(
	parameter int CYC_PER_MS = RFVC_CYC_PER_MS
)(
	input  wire logic        clock,            // 100 MHz system clock
	input  wire logic        arst_n,           // asynchronous reset, active low
	input  wire logic        cmd_valid,        // parsed command present
	input  rfvc_cmd_e        cmd_code,         // command code
	input  wire logic [7:0]  cmd_arg0,         // block, address, sector, source, off time
	input  wire logic [7:0]  cmd_arg1,         // data, key type, target, recovery time
	input  wire logic [31:0] cmd_value,        // four-byte value or block data
	input  wire logic [47:0] cmd_key,          // supplied key bytes
	input  wire logic        cmd_key_cr,       // carriage return sent instead of key
	output logic             cmd_ready_q,      // engine idle, command taken when valid
	output logic             ans_valid_q,      // answer pulse
	output logic [2:0]       ans_len_q,        // answer length in bytes
	output logic [31:0]      ans_data_q,       // answer bytes, single byte in low bits
	output logic             ans_ver_q,        // pulse: send version string plus CR LF
	input  wire logic        text_mode,        // link is in text mode
	input  wire logic        startup_msg_off,  // start-up message disabled in config reg 2
	output logic             tag_req_q,        // tag operation request pulse
	output rfvc_top_e        tag_op_q,         // tag operation
	output logic [7:0]       tag_blk_q,        // block or sector
	output logic [7:0]       tag_dst_q,        // copy target block
	output logic [31:0]      tag_val_q,        // operand value or write data
	output logic [47:0]      tag_key_q,        // explicit key for login
	output logic             tag_key_b_q,      // login with key B
	output logic             tag_key_st_q,     // login with stored key
	output logic [4:0]       tag_key_idx_q,    // stored key index
	input  wire logic        tag_done,         // tag operation finished pulse
	input  rfvc_tst_e        tag_status,       // tag operation outcome
	input  wire logic [31:0] tag_rdata,        // value or data read back
	input  wire logic        tag_is_value,     // read block is in value format
	output logic             tag_reset_q,      // pulse: reset all tags in field
	output logic             field_on_q,       // antenna field enable
	output logic             ps_wr_q,          // parameter store write pulse
	output logic             ps_rd_q,          // parameter store read pulse
	output logic [7:0]       ps_addr_q,        // parameter store address
	output logic [7:0]       ps_wdata_q,       // parameter store write byte
	input  wire logic        ps_done,          // store access finished pulse
	input  wire logic [7:0]  ps_rdata,         // store read byte
	input  wire logic [7:0]  cfg_stored,       // start-up settings as held in the store
	output logic             cfg_load_q,       // pulse: stored settings being loaded
	output logic [7:0]       cfg_active_q      // settings in force
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_PS_WR, ST_PS_RD, ST_FLD_OFF, ST_FLD_REC,
		ST_SRC_RD, ST_TAG_OP, ST_VERIFY, ST_AUTH, ST_RST
	} rfvc_st_e;

	function automatic logic fn_in(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		fn_in = (v >= lo) && (v <= hi);
	endfunction

	// Tag outcome to answer byte; other failures fall back to the caller's code
	function automatic logic [7:0] fn_err(input rfvc_tst_e s, input logic [7:0] other);
		fn_err = (s == TS_NOTAG)      ? RFVC_ERR_NOTAG :
		         (s == TS_NOT_TYPE_A) ? RFVC_ERR_MODE  : other;
	endfunction

	logic rst_s1_q;
	logic rst_n;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	rfvc_st_e    state_q, state_d;
	rfvc_cmd_e   op_q, op_d;
	logic [7:0]  arg1_q, arg1_d;
	logic [31:0] ans_data_d;
	logic [2:0]  ans_len_d;
	logic        ans_valid_d, ans_ver_d, tag_req_d, tag_reset_d, field_on_d;
	logic        ps_wr_d, ps_rd_d, cfg_load_d, tmr_start, boot_q;
	rfvc_top_e   tag_op_d;
	logic [7:0]  tag_blk_d, tag_dst_d, ps_addr_d, ps_wdata_d, tmr_ms;
	logic [31:0] tag_val_d;
	logic [47:0] tag_key_d;
	logic        tag_key_b_d, tag_key_st_d;
	logic [4:0]  tag_key_idx_d;
	wire         tmr_done;

	wire take       = cmd_valid && cmd_ready_q;
	wire short_oor  = (cmd_arg0 > RFVC_SHORT_BLK_MAX);
	wire ps_oor     = !fn_in(cmd_arg0, RFVC_PS_ADDR_MIN, RFVC_PS_ADDR_MAX);
	wire sector_oor = (cmd_arg0 > RFVC_SECTOR_MAX);

	// Login key-type decode
	wire       kt_aa    = (cmd_arg1 == RFVC_KT_A_DATA);
	wire       kt_bb    = (cmd_arg1 == RFVC_KT_B_DATA);
	wire       kt_ff    = (cmd_arg1 == RFVC_KT_A_ONES);
	wire       kt_st_a  = fn_in(cmd_arg1, RFVC_KT_A_BASE, RFVC_KT_A_TOP);
	wire       kt_st_b  = fn_in(cmd_arg1, RFVC_KT_B_BASE, RFVC_KT_B_TOP);
	wire       kt_ok    = kt_aa || kt_bb || kt_ff || kt_st_a || kt_st_b;
	wire [7:0] kt_idx_a = cmd_arg1 - RFVC_KT_A_BASE;
	wire [7:0] kt_idx_b = cmd_arg1 - RFVC_KT_B_BASE;
	// Index is zero unless a stored key is used, so the tag side sees no stray value
	wire [4:0] kt_idx   = kt_st_a ? kt_idx_a[4:0] : kt_st_b ? kt_idx_b[4:0] : 5'h00;
	wire [47:0] kt_key  = kt_ff      ? RFVC_TKEY_ONES :
	                      !cmd_key_cr ? cmd_key :
	                      kt_bb      ? RFVC_TKEY_B : RFVC_TKEY_A;
	wire       cfg_cap  = boot_q || cfg_load_q;
	wire       is_value_op = (op_q == CMD_INC) || (op_q == CMD_DEC) || (op_q == CMD_COPY);

	always_comb
	begin
		state_d       = state_q;
		op_d          = op_q;
		arg1_d        = arg1_q;
		ans_valid_d   = 1'b0;
		ans_len_d     = ans_len_q;
		ans_data_d    = ans_data_q;
		ans_ver_d     = 1'b0;
		tag_req_d     = 1'b0;
		tag_op_d      = tag_op_q;
		tag_blk_d     = tag_blk_q;
		tag_dst_d     = tag_dst_q;
		tag_val_d     = tag_val_q;
		tag_key_d     = tag_key_q;
		tag_key_b_d   = tag_key_b_q;
		tag_key_st_d  = tag_key_st_q;
		tag_key_idx_d = tag_key_idx_q;
		tag_reset_d   = 1'b0;
		field_on_d    = field_on_q;
		ps_wr_d       = 1'b0;
		ps_rd_d       = 1'b0;
		ps_addr_d     = ps_addr_q;
		ps_wdata_d    = ps_wdata_q;
		cfg_load_d    = 1'b0;
		tmr_start     = 1'b0;
		tmr_ms        = arg1_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (take)
				begin
					op_d      = cmd_code;
					arg1_d    = cmd_arg1;
					tag_blk_d = cmd_arg0;
					tag_dst_d = cmd_arg1;
					tag_val_d = cmd_value;
					ans_len_d = RFVC_LEN_BYTE;
					unique case (cmd_code)
						CMD_BLK_PUT_SHORT, CMD_BLK_PUT_LONG:
						begin
							if (cmd_code == CMD_BLK_PUT_SHORT && short_oor)
							begin
								ans_valid_d = 1'b1;
								ans_data_d  = {24'h000000, RFVC_ERR_RANGE};
							end
							else
							begin
								tag_req_d = 1'b1;
								tag_op_d  = TOP_WRITE;
								state_d   = ST_TAG_OP;
							end
						end
						CMD_PS_WRITE:
						begin
							if (ps_oor)
							begin
								ans_valid_d = 1'b1;
								ans_data_d  = {24'h000000, RFVC_ERR_RANGE};
							end
							else
							begin
								// Only the store is written; settings in force stay
								ps_wr_d    = 1'b1;
								ps_addr_d  = cmd_arg0;
								ps_wdata_d = cmd_arg1;
								state_d    = ST_PS_WR;
							end
						end
						CMD_RESET:
						begin
							cfg_load_d  = 1'b1;
							tag_reset_d = 1'b1;
							state_d     = ST_RST;
						end
						CMD_FIELD_RESET:
						begin
							field_on_d = 1'b0;
							tmr_start  = 1'b1;
							tmr_ms     = cmd_arg0;
							state_d    = ST_FLD_OFF;
						end
						CMD_INC, CMD_DEC, CMD_COPY:
						begin
							// Source first: format check before any change to the tag
							tag_req_d = 1'b1;
							tag_op_d  = TOP_READ;
							state_d   = ST_SRC_RD;
						end
						CMD_LOGIN:
						begin
							if (sector_oor || !kt_ok)
							begin
								ans_valid_d = 1'b1;
								ans_data_d  = {24'h000000, RFVC_ERR_RANGE};
							end
							else
							begin
								tag_req_d     = 1'b1;
								tag_op_d      = TOP_AUTH;
								tag_key_d     = kt_key;
								tag_key_b_d   = kt_bb || kt_st_b;
								tag_key_st_d  = kt_st_a || kt_st_b;
								tag_key_idx_d = kt_idx;
								state_d       = ST_AUTH;
							end
						end
						default:
						begin
							ans_valid_d = 1'b1;
							ans_data_d  = {24'h000000, RFVC_ERR_RANGE};
						end
					endcase
				end
			end
			ST_PS_WR:
			begin
				if (ps_done)
				begin
					ps_rd_d = 1'b1;
					state_d = ST_PS_RD;
				end
			end
			ST_PS_RD:
			begin
				if (ps_done)
				begin
					ans_valid_d = 1'b1;
					ans_data_d  = {24'h000000,
						(ps_rdata == ps_wdata_q) ? ps_rdata : RFVC_ERR_FAIL};
					state_d     = ST_IDLE;
				end
			end
			ST_FLD_OFF:
			begin
				if (tmr_done)
				begin
					field_on_d = 1'b1;
					tmr_start  = 1'b1;
					state_d    = ST_FLD_REC;
				end
			end
			ST_FLD_REC:
			begin
				if (tmr_done)
				begin
					ans_valid_d = 1'b1;
					ans_data_d  = {24'h000000, RFVC_ACK_FIELD};
					state_d     = ST_IDLE;
				end
			end
			ST_SRC_RD:
			begin
				if (tag_done)
				begin
					if (tag_status != TS_OK || !tag_is_value)
					begin
						ans_valid_d = 1'b1;
						ans_data_d  = {24'h000000, (tag_status != TS_OK) ?
							fn_err(tag_status, RFVC_ERR_FAIL) : RFVC_ERR_VALUE};
						state_d     = ST_IDLE;
					end
					else
					begin
						// Target format of a copy is checked only at read-back, after the copy
						tag_req_d = 1'b1;
						tag_op_d  = (op_q == CMD_INC) ? TOP_INC :
						            (op_q == CMD_DEC) ? TOP_DEC : TOP_COPY;
						state_d   = ST_TAG_OP;
					end
				end
			end
			ST_TAG_OP:
			begin
				if (tag_done)
				begin
					if (tag_status != TS_OK)
					begin
						ans_valid_d = 1'b1;
						ans_data_d  = {24'h000000, fn_err(tag_status, RFVC_ERR_FAIL)};
						state_d     = ST_IDLE;
					end
					else
					begin
						tag_req_d = 1'b1;
						tag_op_d  = TOP_READ;
						tag_blk_d = (op_q == CMD_COPY) ? tag_dst_q : tag_blk_q;
						state_d   = ST_VERIFY;
					end
				end
			end
			ST_VERIFY:
			begin
				if (tag_done)
				begin
					ans_valid_d = 1'b1;
					if (tag_status != TS_OK || (is_value_op && !tag_is_value))
						ans_data_d = {24'h000000, fn_err(tag_status, RFVC_ERR_FAIL)};
					else
					begin
						ans_len_d  = RFVC_LEN_WORD;
						ans_data_d = tag_rdata;
					end
					state_d = ST_IDLE;
				end
			end
			ST_AUTH:
			begin
				if (tag_done)
				begin
					ans_valid_d = 1'b1;
					ans_data_d  = {24'h000000, (tag_status == TS_OK) ? RFVC_LOGIN_OK :
						(tag_status == TS_AUTH_FAIL) ? RFVC_ERR_AUTH :
						fn_err(tag_status, RFVC_ERR_FAIL)};
					state_d     = ST_IDLE;
				end
			end
			ST_RST:
			begin
				ans_ver_d = text_mode && !startup_msg_off;
				state_d   = ST_IDLE;
			end
		endcase
	end

	rfvc_ms_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timer (
		.clock (clock),
		.rst_n (rst_n),
		.start (tmr_start),
		.ms    (tmr_ms),
		.done  (tmr_done)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			op_q    <= CMD_RESET;
			arg1_q  <= 8'h00;
			boot_q  <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			op_q    <= op_d;
			arg1_q  <= arg1_d;
			boot_q  <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_ready_q   <= 1'b0;
			ans_valid_q   <= 1'b0;
			ans_len_q     <= RFVC_LEN_BYTE;
			ans_data_q    <= RFVC_DATA_RST;
			ans_ver_q     <= 1'b0;
			tag_req_q     <= 1'b0;
			tag_op_q      <= TOP_READ;
			tag_blk_q     <= 8'h00;
			tag_dst_q     <= 8'h00;
			tag_val_q     <= RFVC_DATA_RST;
			tag_key_q     <= RFVC_TKEY_A;
			tag_key_b_q   <= 1'b0;
			tag_key_st_q  <= 1'b0;
			tag_key_idx_q <= 5'h00;
			tag_reset_q   <= 1'b0;
			field_on_q    <= 1'b1;
			ps_wr_q       <= 1'b0;
			ps_rd_q       <= 1'b0;
			ps_addr_q     <= 8'h00;
			ps_wdata_q    <= 8'h00;
			cfg_load_q    <= 1'b0;
			cfg_active_q  <= RFVC_CFG_RST;
		end
		else
		begin
			// Ready returns one cycle after an answer, so two answers never touch
			cmd_ready_q   <= (state_d == ST_IDLE) && (state_q == ST_IDLE) && !take;
			ans_valid_q   <= ans_valid_d;
			ans_len_q     <= ans_len_d;
			ans_data_q    <= ans_data_d;
			ans_ver_q     <= ans_ver_d;
			tag_req_q     <= tag_req_d;
			tag_op_q      <= tag_op_d;
			tag_blk_q     <= tag_blk_d;
			tag_dst_q     <= tag_dst_d;
			tag_val_q     <= tag_val_d;
			tag_key_q     <= tag_key_d;
			tag_key_b_q   <= tag_key_b_d;
			tag_key_st_q  <= tag_key_st_d;
			tag_key_idx_q <= tag_key_idx_d;
			tag_reset_q   <= tag_reset_d;
			field_on_q    <= field_on_d;
			ps_wr_q       <= ps_wr_d;
			ps_rd_q       <= ps_rd_d;
			ps_addr_q     <= ps_addr_d;
			ps_wdata_q    <= ps_wdata_d;
			cfg_load_q    <= cfg_load_d;
			// Captured only at boot or soft reset, never on a store write
			if (cfg_cap)
				cfg_active_q <= cfg_stored;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_take_field;
		take && cmd_code == CMD_FIELD_RESET;
	endsequence
	sequence s_off_expired;
		state_q == ST_FLD_OFF && tmr_done;
	endsequence

	AST_SHORT_RANGE: assert property (take && cmd_code == CMD_BLK_PUT_SHORT && short_oor
		|=> ans_valid_q && ans_data_q[7:0] == RFVC_ERR_RANGE && !tag_req_q)
		else $error("short block write above limit not refused");
	AST_PS_RANGE: assert property (take && cmd_code == CMD_PS_WRITE && ps_oor
		|=> ans_valid_q && ans_data_q[7:0] == RFVC_ERR_RANGE && !ps_wr_q)
		else $error("store address out of range not refused");
	AST_PS_READBACK: assert property (state_q == ST_PS_RD && ps_done
		&& ps_rdata != ps_wdata_q |=> ans_valid_q && ans_data_q[7:0] == RFVC_ERR_FAIL)
		else $error("store read-back mismatch not reported");
	AST_CFG_HOLD: assert property (!$stable(cfg_active_q) |-> $past(cfg_cap))
		else $error("active settings changed without reset");
	AST_RESET_SEQ: assert property (take && cmd_code == CMD_RESET
		|=> cfg_load_q && tag_reset_q ##1 !ans_valid_q)
		else $error("reset did not reload settings and reset tags");
	AST_VERSION: assert property (state_q == ST_RST
		|=> ans_ver_q == $past(text_mode && !startup_msg_off) && !ans_valid_q)
		else $error("start-up message wrong after reset");
	AST_FIELD_OFF: assert property (s_take_field |=> !field_on_q)
		else $error("field not switched off");
	AST_FIELD_ON: assert property (s_off_expired |=> field_on_q && state_q == ST_FLD_REC)
		else $error("field not re-enabled after off time");
	AST_VALUE_FMT: assert property (state_q == ST_SRC_RD && tag_done && tag_status == TS_OK
		&& !tag_is_value |=> ans_data_q[7:0] == RFVC_ERR_VALUE && !tag_req_q)
		else $error("non-value source not aborted");
	AST_NOTAG: assert property (tag_done && tag_status == TS_NOTAG && state_q != ST_IDLE
		|=> ans_valid_q && ans_data_q[7:0] == RFVC_ERR_NOTAG)
		else $error("silent tag not reported");
	AST_RESULT: assert property (state_q == ST_VERIFY && tag_done && tag_status == TS_OK
		&& tag_is_value && is_value_op
		|=> ans_len_q == RFVC_LEN_WORD && ans_data_q == $past(tag_rdata))
		else $error("value result not returned");
	AST_LOGIN_RANGE: assert property (take && cmd_code == CMD_LOGIN && sector_oor
		|=> ans_data_q[7:0] == RFVC_ERR_RANGE && !tag_req_q)
		else $error("login sector out of range accepted");
	AST_ONE_ANSWER: assert property (ans_valid_q |=> !ans_valid_q && !ans_ver_q)
		else $error("second answer for one command");
endmodule

/* rfvc_pkg.sv */
// Purpose: Shared constants and types of the reader value/command engine, plus its ms timer.
// Assumes: 100 MHz clock; command bytes already parsed by the serial framing layer.
// Notes:   The timer length is a parameter so that simulation can shorten a millisecond.

package rfvc_pkg;

	// Host command codes after parsing
	typedef enum logic [3:0] {
		CMD_BLK_PUT_SHORT,
		CMD_BLK_PUT_LONG,
		CMD_PS_WRITE,
		CMD_RESET,
		CMD_FIELD_RESET,
		CMD_INC,
		CMD_DEC,
		CMD_COPY,
		CMD_LOGIN
	} rfvc_cmd_e;

	// Operations requested from the tag transceiver
	typedef enum logic [2:0] {
		TOP_READ,
		TOP_WRITE,
		TOP_INC,
		TOP_DEC,
		TOP_COPY,
		TOP_AUTH
	} rfvc_top_e;

	// Outcome reported by the tag transceiver
	typedef enum logic [2:0] {
		TS_OK,
		TS_NOTAG,
		TS_NOT_TYPE_A,
		TS_FAIL,
		TS_AUTH_FAIL
	} rfvc_tst_e;

	// Answer codes (ASCII)
	localparam logic [7:0] RFVC_ERR_RANGE = 8'h52;
	localparam logic [7:0] RFVC_ERR_FAIL  = 8'h46;
	localparam logic [7:0] RFVC_ERR_NOTAG = 8'h4E;
	localparam logic [7:0] RFVC_ERR_MODE  = 8'h4F;
	localparam logic [7:0] RFVC_ERR_VALUE = 8'h49;
	localparam logic [7:0] RFVC_ERR_AUTH  = 8'h58;
	localparam logic [7:0] RFVC_ACK_FIELD = 8'h59;
	localparam logic [7:0] RFVC_LOGIN_OK  = 8'h4C;

	// Parameter ranges
	localparam logic [7:0] RFVC_SHORT_BLK_MAX = 8'h40;
	localparam logic [7:0] RFVC_PS_ADDR_MIN   = 8'h0A;
	localparam logic [7:0] RFVC_PS_ADDR_MAX   = 8'hEF;
	localparam logic [7:0] RFVC_SECTOR_MAX    = 8'h3F;

	// Login key-type byte encodings
	localparam logic [7:0] RFVC_KT_A_DATA  = 8'hAA;
	localparam logic [7:0] RFVC_KT_B_DATA  = 8'hBB;
	localparam logic [7:0] RFVC_KT_A_ONES  = 8'hFF;
	localparam logic [7:0] RFVC_KT_A_BASE  = 8'h10;
	localparam logic [7:0] RFVC_KT_A_TOP   = 8'h2F;
	localparam logic [7:0] RFVC_KT_B_BASE  = 8'h30;
	localparam logic [7:0] RFVC_KT_B_TOP   = 8'h4F;

	// Built-in transport keys
	localparam logic [47:0] RFVC_TKEY_A    = 48'hA0A1A2A3A4A5;
	localparam logic [47:0] RFVC_TKEY_B    = 48'hB0B1B2B3B4B5;
	localparam logic [47:0] RFVC_TKEY_ONES = 48'hFFFFFFFFFFFF;

	// Answer lengths in bytes
	localparam logic [2:0] RFVC_LEN_BYTE = 3'h1;
	localparam logic [2:0] RFVC_LEN_WORD = 3'h4;

	// Reset values
	localparam logic [7:0]  RFVC_CFG_RST  = 8'h00;
	localparam logic [31:0] RFVC_DATA_RST = 32'h00000000;

	// Timing: one millisecond in clock cycles, rounded up
	localparam int RFVC_MS_NS       = 1000000;
	localparam int RFVC_CLK_NS      = 10;
	localparam int RFVC_CYC_PER_MS  = (RFVC_MS_NS + RFVC_CLK_NS - 1) / RFVC_CLK_NS;

endpackage

`timescale 1ns/1ns

// Counts a number of milliseconds and pulses done once; zero gives done next cycle
module rfvc_ms_timer
	import rfvc_pkg::*;
#(
	parameter int CYC_PER_MS = RFVC_CYC_PER_MS
)(
	input  wire logic       clock,  // system clock
	input  wire logic       rst_n,  // synchronised reset, active low
	input  wire logic       start,  // load ms and begin counting
	input  wire logic [7:0] ms,     // duration in milliseconds
	output logic            done    // one-cycle pulse at expiry
);
	localparam int CW = $clog2(CYC_PER_MS + 1);

	logic [CW-1:0] cyc_q;
	logic [7:0]    ms_left_q;
	logic          run_q;
	wire           ms_tick = (cyc_q == CW'(CYC_PER_MS - 1));

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cyc_q     <= '0;
			ms_left_q <= 8'h00;
			run_q     <= 1'b0;
			done      <= 1'b0;
		end
		else if (start)
		begin
			cyc_q     <= '0;
			ms_left_q <= ms;
			run_q     <= (ms != 8'h00);
			done      <= (ms == 8'h00);
		end
		else
		begin
			done  <= run_q && ms_tick && (ms_left_q == 8'h01);
			cyc_q <= (!run_q || ms_tick) ? '0 : cyc_q + CW'(1);
			if (run_q && ms_tick)
			begin
				ms_left_q <= ms_left_q - 8'h01;
				run_q     <= (ms_left_q != 8'h01);
			end
		end
	end
endmodule

/* rfvc_tag_model.sv */
// Purpose: Stand-in for the tag transceiver and parameter store facing the engine
// Assumes: One request at a time, as the engine issues them
// Notes:   isv low also corrupts store read-back so that a failed check can be forced
`timescale 1ns/1ns
module rfvc_tag_model
	import rfvc_pkg::*;
(
	input  wire logic        clock,        // system clock
	input  wire logic        tag_req_q,    // tag request pulse
	input  rfvc_top_e        tag_op_q,     // tag operation
	input  wire logic [31:0] tag_val_q,    // operand
	input  rfvc_tst_e        st,           // outcome to report
	input  wire logic        isv,          // block in value format
	input  wire logic        slow,         // answer two cycles later
	output logic             tag_done,     // tag done pulse
	output rfvc_tst_e        tag_status,   // tag outcome
	output logic [31:0]      tag_rdata,    // read data
	output logic             tag_is_value, // value format flag
	input  wire logic        ps_wr_q,      // store write pulse
	input  wire logic        ps_rd_q,      // store read pulse
	input  wire logic [7:0]  ps_wdata_q,   // store write byte
	output logic             ps_done,      // store done pulse
	output logic [7:0]       ps_rdata      // store read byte
);
	logic [2:0]  d = 3'h0;
	logic [2:0]  p = 3'h0;
	logic [31:0] v = 32'h100;
	logic [7:0]  m = 8'h00;
	// Outside the done pulse the data lines show the inverse, never a stale match
	assign tag_done = slow ? d[2] : d[0];
	assign ps_done = slow ? p[2] : p[0];
	assign tag_status = st;
	assign tag_is_value = tag_done ? isv : ~isv;
	assign tag_rdata = tag_done ? v : ~v;
	assign ps_rdata = ps_done ? m ^ {7'h00, ~isv} : ~m;
	always_ff @(posedge clock)
	begin
		d <= {d[1:0], tag_req_q};
		p <= {p[1:0], ps_wr_q | ps_rd_q};
		if (tag_req_q && st == TS_OK && tag_op_q == TOP_INC)
			v <= v + tag_val_q;
		if (tag_req_q && st == TS_OK && tag_op_q == TOP_DEC)
			v <= v - tag_val_q;
		if (tag_req_q && st == TS_OK && tag_op_q == TOP_WRITE)
			v <= tag_val_q;
		if (ps_wr_q)
			m <= ps_wdata_q;
	end
endmodule

/* tb_rfvc_engine.sv */
// Purpose: Self-checking bench of the command engine
// Assumes: One millisecond shortened to 5 cycles
// Notes:   Inputs move at the falling edge
`timescale 1ns/1ns
module tb_rfvc_engine
	import rfvc_pkg::*;
();
	logic        clock = 1'h0, arst_n = 1'h0, cmd_valid = 1'h0, cmd_key_cr = 1'h0;
	logic        text_mode = 1'h0, startup_msg_off = 1'h0, isv = 1'h1, slow = 1'h0;
	rfvc_cmd_e   cmd_code = CMD_RESET;
	rfvc_tst_e   st = TS_OK, tag_status;
	logic [7:0]  cmd_arg0 = 8'h00, cmd_arg1 = 8'h00, cfg_stored = 8'h5A;
	logic [31:0] cmd_value = 32'h0, got, ans_data_q, tag_val_q, tag_rdata;
	logic [47:0] cmd_key = 48'h0123456789AB, tag_key_q;
	logic        cmd_ready_q, ans_valid_q, ans_ver_q, tag_req_q, tag_key_b_q, tag_key_st_q;
	logic        tag_done, tag_is_value, tag_reset_q, field_on_q, cfg_load_q;
	logic        ps_wr_q, ps_rd_q, ps_done;
	logic [2:0]  ans_len_q;
	rfvc_top_e   tag_op_q;
	logic [4:0]  tag_key_idx_q;
	logic [7:0]  tag_blk_q, tag_dst_q, ps_addr_q, ps_wdata_q, ps_rdata, cfg_active_q;
	logic [54:0] key;
	logic [15:0] blk;
	logic [8:0]  ops;
	int          n_mismatch = 0, n_checks = 0, nreq, nver, nlow;
	rfvc_engine #(.CYC_PER_MS(5)) dut (.*);
	rfvc_tag_model model (.*);
	initial forever #5 clock = ~clock;
	task automatic close_out();
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(logic [63:0] a, logic [63:0] e);
		n_checks++;
		if (a !== e)
		begin
			n_mismatch++;
			$display("Error %0t: got %h want %h", $time, a, e);
		end
	endtask
	// Reset gives no answer pulse, so its window is a few cycles only
	task automatic cmd(rfvc_cmd_e c, logic [7:0] a0, logic [7:0] a1, logic [31:0] v);
		int i;
		logic fin;
		for (i = 0; i < 300 && cmd_ready_q !== 1'h1; i++)
			@(negedge clock);
		nreq = 0;
		nver = 0;
		nlow = 0;
		fin = 1'h0;
		ops = 9'h000;
		cmd_code = c;
		cmd_arg0 = a0;
		cmd_arg1 = a1;
		cmd_value = v;
		cmd_valid = 1'h1;
		@(negedge clock);
		cmd_valid = 1'h0;
		// Pulses launched by the take edge stand now, so sample before waiting
		for (i = i / 300 * 300; i < 300 && !fin; i++)
		begin
			nreq += tag_req_q + ps_wr_q + tag_reset_q + cfg_load_q;
			nver += ans_ver_q;
			nlow += !field_on_q;
			if (tag_req_q)
				ops = {ops[5:0], tag_op_q};
			if (tag_req_q)
				key = {tag_key_st_q, tag_key_b_q, tag_key_idx_q, tag_key_q};
			if (tag_req_q)
				blk = {tag_blk_q, tag_dst_q};
			if (ps_wr_q)
				blk = {ps_addr_q, ps_wdata_q};
			fin = ans_valid_q === 1'h1 || (c == CMD_RESET && i > 3);
			if (!fin)
				@(negedge clock);
		end
		got = ans_data_q;
		if (i == 300 && !fin)
		begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic sc_range();
		cmd(CMD_BLK_PUT_SHORT, 8'h41, 8'h00, 32'h0);
		chk({got[7:0], 8'(nreq)}, {RFVC_ERR_RANGE, 8'h00});
		cmd(CMD_PS_WRITE, 8'h09, 8'h11, 32'h0);
		chk({got[7:0], 8'(nreq)}, {RFVC_ERR_RANGE, 8'h00});
		cmd(CMD_PS_WRITE, 8'hF0, 8'h11, 32'h0);
		chk(got[7:0], RFVC_ERR_RANGE);
		cmd(CMD_LOGIN, 8'h40, RFVC_KT_A_DATA, 32'h0);
		chk({got[7:0], 8'(nreq)}, {RFVC_ERR_RANGE, 8'h00});
		cmd(CMD_LOGIN, 8'h02, 8'h50, 32'h0);
		chk(got[7:0], RFVC_ERR_RANGE);
	endtask
	task automatic sc_store();
		cmd(CMD_PS_WRITE, 8'h0A, 8'h01, 32'h0);
		chk({got[7:0], cfg_active_q, blk}, {8'h01, 8'h5A, 8'h0A, 8'h01});
		isv = 1'h0;
		cmd(CMD_PS_WRITE, 8'hEF, 8'h3C, 32'h0);
		chk(got[7:0], RFVC_ERR_FAIL);
		isv = 1'h1;
	endtask
	task automatic sc_login();
		cmd_key_cr = 1'h1;
		cmd(CMD_LOGIN, 8'h02, RFVC_KT_A_DATA, 32'h0);
		chk({got[7:0], key}, {RFVC_LOGIN_OK, 7'h00, RFVC_TKEY_A});
		cmd(CMD_LOGIN, 8'h0E, 8'h14, 32'h0);
		chk(key[54:48], {2'h2, 5'h04});
		cmd(CMD_LOGIN, 8'h05, 8'h30, 32'h0);
		chk(key[54:48], {2'h3, 5'h00});
		cmd(CMD_LOGIN, 8'h3F, RFVC_KT_B_DATA, 32'h0);
		chk(key[53:0], {1'h1, 5'h00, RFVC_TKEY_B});
		cmd_key_cr = 1'h0;
		cmd(CMD_LOGIN, 8'h3F, RFVC_KT_B_DATA, 32'h0);
		chk(key[53:0], {1'h1, 5'h00, cmd_key});
		cmd(CMD_LOGIN, 8'h04, RFVC_KT_A_ONES, 32'h0);
		chk(key, {7'h00, RFVC_TKEY_ONES});
		st = TS_AUTH_FAIL;
		cmd(CMD_LOGIN, 8'h01, RFVC_KT_A_DATA, 32'h0);
		chk(got[7:0], RFVC_ERR_AUTH);
		st = TS_OK;
	endtask
	task automatic sc_value();
		slow = 1'h1;
		cmd(CMD_INC, 8'h04, 8'h00, 32'h5);
		chk({ans_len_q, got, ops}, {RFVC_LEN_WORD, 32'h105, TOP_READ, TOP_INC, TOP_READ});
		slow = 1'h0;
		cmd(CMD_DEC, 8'h04, 8'h00, 32'h3);
		chk({got, ops}, {32'h105 - 32'h3, TOP_READ, TOP_DEC, TOP_READ});
		cmd(CMD_COPY, 8'h04, 8'h05, 32'h0);
		chk({got, blk, ops}, {32'h102, 8'h05, 8'h05, TOP_READ, TOP_COPY, TOP_READ});
		isv = 1'h0;
		cmd(CMD_COPY, 8'h04, 8'h05, 32'h0);
		chk(got[7:0], RFVC_ERR_VALUE);
		isv = 1'h1;
		st = TS_NOTAG;
		cmd(CMD_INC, 8'h04, 8'h00, 32'h1);
		chk(got[7:0], RFVC_ERR_NOTAG);
		st = TS_NOT_TYPE_A;
		cmd(CMD_DEC, 8'h04, 8'h00, 32'h1);
		chk(got[7:0], RFVC_ERR_MODE);
		st = TS_FAIL;
		cmd(CMD_COPY, 8'h04, 8'h05, 32'h0);
		chk(got[7:0], RFVC_ERR_FAIL);
		st = TS_OK;
		cmd(CMD_BLK_PUT_LONG, 8'h41, 8'h00, 32'h00000100);
		chk({got, blk, ops}, {32'h00000100, 8'h41, 8'h00, TOP_READ, TOP_WRITE, TOP_READ});
		cmd(CMD_BLK_PUT_SHORT, 8'h40, 8'h00, 32'h00000077);
		chk({ans_len_q, got}, {RFVC_LEN_WORD, 32'h00000077});
	endtask
	task automatic sc_field();
		cmd(CMD_FIELD_RESET, 8'h01, 8'h01, 32'h0);
		chk({got[7:0], 1'(nlow >= 5 && nlow < 10), field_on_q}, {RFVC_ACK_FIELD, 2'h3});
	endtask
	task automatic sc_reset();
		text_mode = 1'h1;
		cfg_stored = 8'hC3;
		cmd(CMD_RESET, 8'h00, 8'h00, 32'h0);
		chk({8'(nver), 8'(nreq), cfg_active_q}, {8'h01, 8'h02, 8'hC3});
		startup_msg_off = 1'h1;
		cmd(CMD_RESET, 8'h00, 8'h00, 32'h0);
		chk(nver, 0);
		text_mode = 1'h0;
		startup_msg_off = 1'h0;
		cmd(CMD_RESET, 8'h00, 8'h00, 32'h0);
		chk(nver, 0);
	endtask
	initial
	begin
		repeat (10) @(negedge clock);
		arst_n = 1'h1;
		sc_range();
		sc_store();
		sc_login();
		sc_value();
		sc_field();
		sc_reset();
		close_out();
	end
endmodule
